// file: src/osrp_top.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
module osrp_top #(
  parameter int NUM_CH = 4,
  parameter int NUM_HS = 4
) (
  input  wire logic                clock_i,
  input  wire logic                rst_n_i,
  input  wire logic                align_n_i,
  input  wire logic                chip_sleep_pin_n_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic [NUM_CH-1:0]   div_tick_i,
  output logic      [NUM_CH-1:0]   ch_hold_o,
  output logic      [NUM_CH-1:0]   ch_level_o,
  output logic      [4*NUM_CH-1:0] ch_phase_o,
  output logic      [NUM_CH-1:0]   half_a_en_o,
  output logic      [NUM_CH-1:0]   half_b_en_o,
  output logic      [3*NUM_CH-1:0] polarity_o,
  output logic      [2*NUM_HS-1:0] hs_pd_mode_o,
  output logic                     blocks_off_o,
  output logic                     cal_busy_o,
  output logic                     align_active_o
);
  initial begin
    if (NUM_CH < 1 || NUM_CH > 4) $error("NUM_CH must be 1..4");
    if (NUM_HS < 1 || NUM_HS > 4) $error("NUM_HS must be 1..4");
  end

  typedef struct packed {
    logic [2:0]  pin_sync;
    logic        pin_lvl;
    logic [2:0]  slp_sync;
    logic        slp_lvl;
    logic [31:0] ctrl;
    logic [31:0] dist_buf;
    logic [31:0] dist_act;
    logic [31:0] chan_buf;
    logic [31:0] chan_act;
    logic [31:0] outcfg_buf;
    logic [31:0] outcfg_act;
    logic [31:0] hs_buf;
    logic [31:0] hs_act;
    logic [7:0]  cal_cnt;
    logic        cal_run;
    logic [4:0]  rel_cnt;
    logic [4:0]  rel_ticks;
    logic        align_hold;
    logic [2:0]  pu_cnt;
    logic [31:0] rdata;
  } osrp_state_t;

  osrp_state_t st;
  osrp_state_t next_st;

  logic apb_acc;
  logic soft_rst;
  logic req_level;
  logic upd_cmd;
  logic cal_cmd;
  assign apb_acc   = psel_i && penable_i;
  assign upd_cmd   = apb_acc && pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_UPDATE
                     && pwdata_i[osrp_pkg::OSRP_BIT_UPDATE];
  assign cal_cmd   = apb_acc && pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_UPDATE
                     && pwdata_i[osrp_pkg::OSRP_BIT_CAL_START];
  assign soft_rst  = st.ctrl[osrp_pkg::OSRP_BIT_SOFT_RST_LO]
                     || st.ctrl[osrp_pkg::OSRP_BIT_SOFT_RST_HI];
  // any level request sets align_hold, holding included channels outside sleep; release begins when all drop
  assign req_level = !st.pin_lvl
                     || !st.slp_lvl
                     || soft_rst
                     || st.dist_act[osrp_pkg::OSRP_BIT_SOFT_ALIGN]
                     || st.dist_act[osrp_pkg::OSRP_BIT_DIST_PD]
                     || st.cal_run
                     || (st.pu_cnt != 3'h0);

  always_comb begin
    next_st = st;
    // three-stage sampling, change accepted when stages 2 and 3 agree
    next_st.pin_sync = {st.pin_sync[1:0], align_n_i};
    if (st.pin_sync[2] == st.pin_sync[1]) next_st.pin_lvl = st.pin_sync[2];
    next_st.slp_sync = {st.slp_sync[1:0], chip_sleep_pin_n_i};
    if (st.slp_sync[2] == st.slp_sync[1]) next_st.slp_lvl = st.slp_sync[2];
    if (st.pu_cnt != 3'h0) next_st.pu_cnt = st.pu_cnt - 3'h1;
    if (st.cal_run) begin
      if (st.cal_cnt == 8'h00) next_st.cal_run = 1'b0;
      else next_st.cal_cnt = st.cal_cnt - 8'h01;
    end
    // release countdown, measured in channel-divider input ticks
    if (req_level) begin
      next_st.align_hold = 1'b1;
      next_st.rel_cnt    = 5'(osrp_pkg::OSRP_ALIGN_BASE + 1);
    end else if (st.align_hold && div_tick_i[0]) begin
      if (st.rel_cnt == 5'h00) next_st.align_hold = 1'b0;
      else next_st.rel_cnt = st.rel_cnt - 5'h01;
    end
    // independent tick tally since the last request, read only by checks
    if (req_level) next_st.rel_ticks = 5'h00;
    else if (st.align_hold && div_tick_i[0]) next_st.rel_ticks = st.rel_ticks + 5'h01;
    // read data holds until the next read, so the access cycle sees it settled
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        osrp_pkg::OSRP_OFS_CTRL:   next_st.rdata = st.ctrl;
        osrp_pkg::OSRP_OFS_DIST:   next_st.rdata = st.dist_buf;
        osrp_pkg::OSRP_OFS_CHAN:   next_st.rdata = st.chan_buf;
        osrp_pkg::OSRP_OFS_OUTCFG: next_st.rdata = st.outcfg_buf;
        osrp_pkg::OSRP_OFS_HSPD:   next_st.rdata = st.hs_buf;
        osrp_pkg::OSRP_OFS_STATUS:
          next_st.rdata = {29'h0, st.cal_run, st.align_hold, st.slp_lvl};
        default:                   next_st.rdata = osrp_pkg::OSRP_RST_ZERO;
      endcase
    end
    // update command moves buffered writes into the active copies
    if (apb_acc && pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_UPDATE) begin
      if (pwdata_i[osrp_pkg::OSRP_BIT_UPDATE]) begin
        next_st.dist_act   = st.dist_buf;
        next_st.chan_act   = st.chan_buf;
        next_st.outcfg_act = st.outcfg_buf;
        next_st.hs_act     = st.hs_buf;
      end
      if (pwdata_i[osrp_pkg::OSRP_BIT_CAL_START] && !st.cal_run) begin
        next_st.cal_run = 1'b1;
        next_st.cal_cnt = 8'(osrp_pkg::OSRP_CAL_CYCLES);
      end
    end
    if (apb_acc && pwrite_i) begin
      unique case (paddr_i)
        osrp_pkg::OSRP_OFS_CTRL:   next_st.ctrl       = pwdata_i;
        osrp_pkg::OSRP_OFS_DIST:   next_st.dist_buf   = pwdata_i;
        osrp_pkg::OSRP_OFS_CHAN:   next_st.chan_buf   = pwdata_i;
        osrp_pkg::OSRP_OFS_OUTCFG: next_st.outcfg_buf = pwdata_i;
        osrp_pkg::OSRP_OFS_HSPD:   next_st.hs_buf     = pwdata_i;
        default: ;
      endcase
    end
    // soft reset restores defaults at once, no update needed
    if (soft_rst) begin
      next_st.dist_buf   = osrp_pkg::OSRP_RST_ZERO;
      next_st.dist_act   = osrp_pkg::OSRP_RST_ZERO;
      next_st.chan_buf   = osrp_pkg::OSRP_RST_ZERO;
      next_st.chan_act   = osrp_pkg::OSRP_RST_ZERO;
      next_st.outcfg_buf = osrp_pkg::OSRP_RST_ZERO;
      next_st.outcfg_act = osrp_pkg::OSRP_RST_ZERO;
      next_st.hs_buf     = osrp_pkg::OSRP_RST_ZERO;
      next_st.hs_act     = osrp_pkg::OSRP_RST_ZERO;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      st          <= '0;
      st.pin_sync <= 3'h7;
      st.pin_lvl  <= 1'b1;
      st.slp_sync <= 3'h7;
      st.slp_lvl  <= 1'b1;
      st.pu_cnt   <= 3'(osrp_pkg::OSRP_POWERUP_HOLD);
      st.align_hold <= 1'b1;
      st.rel_cnt    <= 5'(osrp_pkg::OSRP_ALIGN_BASE + 1);
    end else begin
      st <= next_st;
    end
  end

  // registers survive sleep untouched, so wake resumes programmed values
  assign blocks_off_o   = !st.slp_lvl;
  assign cal_busy_o     = st.cal_run;
  assign align_active_o = st.align_hold;
  assign pready_o       = 1'b1;
  assign pslverr_o      = 1'b0;
  assign prdata_o       = st.rdata;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [7:0] chf;
    logic [7:0] ocf;
    assign chf = st.chan_act[c*osrp_pkg::OSRP_CH_FIELD +: 8];
    assign ocf = st.outcfg_act[c*osrp_pkg::OSRP_OC_FIELD +: 8];
    // one hold per divider drives all its outputs
    assign ch_hold_o[c]       = st.align_hold && !chf[5] && st.slp_lvl;
    assign ch_level_o[c]      = chf[4];
    assign ch_phase_o[4*c +: 4] = chf[3:0];
    assign half_a_en_o[c]     = !ocf[1] && st.slp_lvl;
    assign half_b_en_o[c]     = !ocf[1] && ocf[0] && ocf[2] && st.slp_lvl;
    assign polarity_o[3*c +: 3] = ocf[7:5];

    AST_EXCL_FREE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      chf[5] |-> !ch_hold_o[c])
      else $error("excluded channel held static");
    AST_UNIT_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      st.align_hold && st.slp_lvl && !chf[5] |-> ch_hold_o[c])
      else $error("included channel not held");
    AST_HALF_A_AUTO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ocf[0] && !ocf[1] && st.slp_lvl |-> half_a_en_o[c])
      else $error("half a not on in single-ended mode");
    AST_PD_BOTH: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ocf[1] |-> !half_a_en_o[c] && !half_b_en_o[c])
      else $error("powerdown left a half on");
  end
  for (genvar h = 0; h < NUM_HS; h++) begin : g_hs
    // sleep forces protective off, never total, to keep bias on
    assign hs_pd_mode_o[2*h +: 2] = !st.slp_lvl ? osrp_pkg::OSRP_HS_PROTECT
                                    : st.hs_act[2*h +: 2];
  end

  AST_HOLD_ON_REQ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_level |=> st.align_hold)
    else $error("hold missing during request");
  AST_RELEASE_DELAY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(req_level) |-> st.align_hold [*8])
    else $error("release too early");
  AST_CAL_HOLDS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(st.cal_run) |=> st.align_hold)
    else $error("calibration did not request alignment");
  AST_SLEEP_OFF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.slp_lvl |-> blocks_off_o && half_a_en_o == '0)
    else $error("sleep did not power down");
  AST_EXCL_TOGGLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.chan_act[5] |-> !ch_hold_o[0])
    else $error("excluded channel held");
  AST_SOFT_RST: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    soft_rst |=> st.chan_act == '0 && st.dist_act == '0)
    else $error("soft reset kept values");
  AST_PIN_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(st.pin_lvl) |=> st.align_hold)
    else $error("pin did not align");
  AST_POWERUP: assert property (@(posedge clock_i) $rose(rst_n_i) |-> st.align_hold)
    else $error("no alignment at power-up");

  // release timing: ticks are tallied apart from the countdown
  AST_RELEASE_ALL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.align_hold |-> ch_hold_o == '0)
    else $error("output held without alignment");
  AST_HOLD_ONLY_REQ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(st.align_hold) |-> $past(req_level))
    else $error("hold began with no request");
  AST_RELEASE_TICKS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(st.align_hold) |-> st.rel_ticks == 5'(osrp_pkg::OSRP_ALIGN_BASE + 2))
    else $error("release tick count wrong");
  AST_RELEASE_ON_TICK: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(st.align_hold) |-> $past(div_tick_i[0]))
    else $error("release off a divider tick");
  AST_RELCNT_BOUND: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.rel_cnt <= 5'(osrp_pkg::OSRP_ALIGN_BASE + 1))
    else $error("release count out of range");
  AST_TICKS_BOUND: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.rel_ticks <= 5'(osrp_pkg::OSRP_ALIGN_BASE + 2))
    else $error("tick tally out of range");
  AST_REQ_RELOADS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    req_level |=> st.rel_cnt == 5'(osrp_pkg::OSRP_ALIGN_BASE + 1) && st.rel_ticks == 5'h00)
    else $error("request did not reload countdown");

  // pin and sleep sampling
  AST_PIN_SHIFT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.pin_sync[2] == $past(st.pin_sync[1]))
    else $error("pin sampler did not shift");
  AST_PIN_FILTER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $changed(st.pin_lvl) |-> $past(st.pin_sync[2]) == $past(st.pin_sync[1]))
    else $error("pin level changed without agreement");
  AST_PIN_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $changed(st.pin_lvl) |-> st.pin_lvl == $past(st.pin_sync[2]))
    else $error("pin level took wrong stage");
  AST_SLEEP_FILTER: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $changed(st.slp_lvl) |-> $past(st.slp_sync[2]) == $past(st.slp_sync[1]))
    else $error("sleep level changed without agreement");

  // request sources
  AST_SLEEP_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.slp_lvl |=> st.align_hold)
    else $error("sleep did not request alignment");
  AST_SOFT_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.dist_act[osrp_pkg::OSRP_BIT_SOFT_ALIGN] |=> st.align_hold)
    else $error("soft align bit ignored");
  AST_DIST_PD_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.dist_act[osrp_pkg::OSRP_BIT_DIST_PD] |=> st.align_hold)
    else $error("distribution powerdown bit ignored");
  AST_SOFT_RST_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    soft_rst |=> st.align_hold)
    else $error("soft reset did not request alignment");

  // register transfer
  AST_UPDATE_COPY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    upd_cmd && !soft_rst |=> st.dist_act == $past(st.dist_buf)
                             && st.chan_act == $past(st.chan_buf))
    else $error("update did not transfer buffers");
  AST_ACTIVE_STABLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !upd_cmd && !soft_rst |=> $stable(st.dist_act) && $stable(st.chan_act))
    else $error("active copy changed without update");
  AST_WRITE_BUF: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    apb_acc && pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_DIST && !soft_rst
    |=> st.dist_buf == $past(pwdata_i))
    else $error("buffered write lost");
  AST_CTRL_KEEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(apb_acc && pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_CTRL) |=> $stable(st.ctrl))
    else $error("soft reset bits cleared themselves");
  AST_READ_CTRL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    psel_i && !penable_i && !pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_CTRL
    |=> prdata_o == $past(st.ctrl))
    else $error("control readback wrong");
  AST_UPDATE_READS_ZERO: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    psel_i && !penable_i && !pwrite_i && paddr_i == osrp_pkg::OSRP_OFS_UPDATE
    |=> prdata_o == 32'h0000_0000)
    else $error("update command did not read zero");
  AST_PREADY_NOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    apb_acc |-> pready_o && !pslverr_o)
    else $error("access not completed at once");
  AST_PHASE_STABLE_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.align_hold && !upd_cmd && !soft_rst |=> $stable(ch_phase_o) && $stable(ch_level_o))
    else $error("preset changed during alignment");

  // calibration
  AST_CAL_START: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cal_cmd && !st.cal_run |=> st.cal_run)
    else $error("calibration did not start");
  AST_CAL_MIN: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(st.cal_run) |-> st.cal_run [*8])
    else $error("calibration ended too soon");
  AST_CAL_END: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    st.cal_run && st.cal_cnt == 8'h00 |=> !st.cal_run)
    else $error("calibration did not end");
  AST_CAL_ENDS_HELD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $fell(st.cal_run) |-> st.align_hold)
    else $error("hold dropped with calibration");

  // outputs and sleep
  AST_HALF_B_NEEDS_A: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (half_b_en_o & ~half_a_en_o) == '0)
    else $error("half b on while half a off");
  AST_HS_SLEEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.slp_lvl |-> hs_pd_mode_o == {NUM_HS{osrp_pkg::OSRP_HS_PROTECT}})
    else $error("high-swing not protective in sleep");
  AST_SLEEP_NO_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.slp_lvl |-> ch_hold_o == '0 && half_b_en_o == '0)
    else $error("outputs active in sleep");
  AST_SLEEP_KEEPS_REGS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !st.slp_lvl && !apb_acc && !soft_rst |=> $stable(st.chan_buf) && $stable(st.outcfg_buf))
    else $error("sleep disturbed settings");

  // reset
  AST_RESET_DEFAULTS: assert property (@(posedge clock_i)
    !rst_n_i |=> st.ctrl == '0 && st.chan_act == '0 && st.outcfg_act == '0)
    else $error("reset left non-default values");
  AST_RESET_HOLD: assert property (@(posedge clock_i)
    !rst_n_i |=> st.align_hold && st.pu_cnt == 3'(osrp_pkg::OSRP_POWERUP_HOLD))
    else $error("reset did not arm alignment");
  AST_POWERUP_DONE: assert property (@(posedge clock_i)
    $rose(rst_n_i) |-> ##[1:8] st.pu_cnt == 3'h0)
    else $error("power-up hold did not expire");

  COV_PIN: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(st.align_hold));
  COV_CAL: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(st.cal_run));
  COV_SLEEP: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(st.slp_lvl));
  COV_SOFT_RST: cover property (@(posedge clock_i) disable iff (!rst_n_i) $fell(soft_rst));
  COV_EXCL: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    st.align_hold && ch_hold_o != '0 && ch_hold_o != {NUM_CH{1'b1}});
endmodule

// file: src/osrp_pkg.sv
package osrp_pkg;
  // apb register byte offsets
  localparam logic [11:0] OSRP_OFS_CTRL     = 12'h000;
  localparam logic [11:0] OSRP_OFS_DIST     = 12'h004;
  localparam logic [11:0] OSRP_OFS_UPDATE   = 12'h008;
  localparam logic [11:0] OSRP_OFS_CHAN     = 12'h00C;
  localparam logic [11:0] OSRP_OFS_OUTCFG   = 12'h010;
  localparam logic [11:0] OSRP_OFS_HSPD     = 12'h014;
  localparam logic [11:0] OSRP_OFS_STATUS   = 12'h018;
  // field positions
  localparam int OSRP_BIT_SOFT_RST_LO  = 2;
  localparam int OSRP_BIT_SOFT_RST_HI  = 5;
  localparam int OSRP_BIT_SOFT_ALIGN   = 0;
  localparam int OSRP_BIT_DIST_PD      = 1;
  localparam int OSRP_BIT_UPDATE       = 0;
  localparam int OSRP_BIT_CAL_START    = 2;
  // channel field: [3:0] phase, [4] start level, [5] exclude; 8 bits per channel
  localparam int OSRP_CH_FIELD         = 8;
  // outcfg field per output: [0] single-ended, [1] powerdown, [2] half b on, [7:5] polarity
  localparam int OSRP_OC_FIELD         = 8;
  // reset values
  localparam logic [31:0] OSRP_RST_ZERO = 32'h0000_0000;
  // timing
  localparam int OSRP_ALIGN_BASE        = 14;
  localparam int OSRP_CAL_CYCLES        = 64;
  localparam int OSRP_POWERUP_HOLD      = 4;
  // high-swing power-down modes
  localparam logic [1:0] OSRP_HS_ON      = 2'h0;
  localparam logic [1:0] OSRP_HS_PROTECT = 2'h2;
  localparam logic [1:0] OSRP_HS_TOTAL   = 2'h3;
endpackage

// file: tb/osrp_div_model.sv
`timescale 1ns/10ps
// behavioural divider bank: common tick, held outputs park at preset level
module osrp_div_model #(
  parameter int NUM_CH = 4,
  parameter int DIV    = 4
) (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic [NUM_CH-1:0] ch_hold_i,
  input  wire logic [NUM_CH-1:0] ch_level_i,
  output logic      [NUM_CH-1:0] div_tick_o,
  output logic      [NUM_CH-1:0] out_clk_o
);
  int cnt;
  initial begin
    cnt = 0;
    div_tick_o = '0;
    out_clk_o = '0;
  end
  // ticks keep running in reset, dividers are not reset by the pin
  always @(posedge clock_i) begin
    cnt <= (cnt == DIV-1) ? 0 : cnt + 1;
    div_tick_o <= {NUM_CH{cnt == DIV-1}};
    for (int c = 0; c < NUM_CH; c++) begin
      if (!rst_n_i || ch_hold_i[c]) begin
        out_clk_o[c] <= ch_level_i[c];
      end else if (cnt == DIV-1) begin
        out_clk_o[c] <= ~out_clk_o[c];
      end
    end
  end
endmodule

// file: tb/osrp_top_bench.sv
`timescale 1ns/10ps
module osrp_top_bench;
  logic        clock_i, rst_n_i, align_n, sleep_n, psel, penable, pwrite, pready;
  logic        boff, cbusy, aact, perr;
  logic [11:0] paddr, pol;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  tick, hold, lvl, hae, hbe;
  logic [15:0] phase;
  logic [7:0]  hspd;
  int          error_cnt, checks_done, n;
  osrp_top u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .align_n_i(align_n),
    .chip_sleep_pin_n_i(sleep_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .div_tick_i(tick), .ch_hold_o(hold), .ch_level_o(lvl),
    .ch_phase_o(phase), .half_a_en_o(hae), .half_b_en_o(hbe), .polarity_o(pol),
    .hs_pd_mode_o(hspd), .blocks_off_o(boff), .cal_busy_o(cbusy), .align_active_o(aact));
  osrp_div_model u_far (.clock_i(clock_i), .rst_n_i(rst_n_i), .ch_hold_i(hold),
    .ch_level_i(lvl), .div_tick_o(tick), .out_clk_o());
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask
  task upd;
    wr(osrp_pkg::OSRP_OFS_UPDATE, 32'h0000_0001);
  endtask
  // release count in divider ticks; bounded so a stuck hold still ends
  task wait_rel;
    n = 0;
    for (int i = 0; i < 600 && aact === 1'b1; i++) begin
      @(posedge clock_i);
      if (tick[0] === 1'b1) n++;
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    give_verdict;
  end
  initial begin
    {rst_n_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {align_n, sleep_n} = 2'b11;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge clock_i);
    check(aact, 1'b1);
    rst_n_i <= 1'b1;
    rdc(osrp_pkg::OSRP_OFS_CHAN, 32'h0);
    wait_rel;
    check(aact, 1'b0);
    $display("test powerup done");
    wr(osrp_pkg::OSRP_OFS_CHAN, 32'h0025_1A03);
    upd;
    check({phase, lvl}, 20'h05A32);
    @(posedge clock_i);
    align_n <= 1'b0;
    repeat (8) @(posedge clock_i);
    check(hold, 4'b1011);
    align_n <= 1'b1;
    wait_rel;
    check(n >= 15 && n <= 17, 1'b1);
    check(hold, 4'b0000);
    $display("test pin align done");
    for (int b = 0; b < 2; b++) begin
      wr(osrp_pkg::OSRP_OFS_DIST, 32'h1 << b);
      check(aact, 1'b0);
      upd;
      repeat (2) @(posedge clock_i);
      check(aact, 1'b1);
      rdc(osrp_pkg::OSRP_OFS_UPDATE, 32'h0);
      wr(osrp_pkg::OSRP_OFS_DIST, 32'h0);
      upd;
      wait_rel;
      check(aact, 1'b0);
    end
    $display("test soft align done");
    wr(osrp_pkg::OSRP_OFS_OUTCFG, 32'hA101_0705);
    wr(osrp_pkg::OSRP_OFS_HSPD, 32'h0000_00B8);
    upd;
    check({hae, hbe}, 8'hD1);
    check(pol, 12'hA00);
    check(hspd, 8'hB8);
    $display("test outputs done");
    @(posedge clock_i);
    sleep_n <= 1'b0;
    repeat (6) @(posedge clock_i);
    check({boff, aact}, 2'b11);
    check(hspd, 8'hAA);
    rdc(osrp_pkg::OSRP_OFS_STATUS, 32'h2);
    wr(osrp_pkg::OSRP_OFS_HSPD, 32'h0000_0008);
    upd;
    @(posedge clock_i);
    sleep_n <= 1'b1;
    wait_rel;
    check({boff, aact, hspd}, 10'h008);
    $display("test sleep done");
    wr(osrp_pkg::OSRP_OFS_UPDATE, 32'h0000_0004);
    repeat (2) @(posedge clock_i);
    check({cbusy, aact}, 2'b11);
    for (int i = 0; i < 200 && cbusy === 1'b1; i++) @(posedge clock_i);
    check({cbusy, aact}, 2'b01);
    wait_rel;
    check(aact, 1'b0);
    $display("test calibration done");
    wr(osrp_pkg::OSRP_OFS_CTRL, 32'h0000_0024);
    repeat (2) @(posedge clock_i);
    check(aact, 1'b1);
    rdc(osrp_pkg::OSRP_OFS_OUTCFG, 32'h0);
    wr(osrp_pkg::OSRP_OFS_CTRL, 32'h0);
    wait_rel;
    check(aact, 1'b0);
    wr(12'h100, 32'hFFFF_FFFF);
    rdc(12'h100, 32'h0);
    check(perr, 1'b0);
    $display("test soft reset done");
    wr(osrp_pkg::OSRP_OFS_CHAN, 32'h0000_0011);
    upd;
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(osrp_pkg::OSRP_OFS_CHAN, 32'h0);
    check(aact, 1'b1);
    wait_rel;
    check(aact, 1'b0);
    $display("test hard reset done");
    give_verdict;
  end
endmodule
